// ### acs_pkg.sv
/*
 * Package for the converter sequencer register block: register offsets,
 * bit positions, reset values, channel codes and the signal bundles that
 * travel between the sequencer and the analogue front end.
 * Assumes an 8-bit register port and one device clock.
 */
package acs_pkg;

	// Register offsets on the register port
	localparam logic [7:0] ADDR_FRONTEND_CTRL  = 8'h2e;
	localparam logic [7:0] ADDR_SCALER_CTRL    = 8'h2f;
	localparam logic [7:0] ADDR_RT_SEL_LOW     = 8'h32;
	localparam logic [7:0] ADDR_RT_SEL_MID     = 8'h33;
	localparam logic [7:0] ADDR_RT_SEL_HIGH    = 8'h34;
	localparam logic [7:0] ADDR_SW_CHAN_SEL    = 8'h35;
	localparam logic [7:0] ADDR_START_STATUS   = 8'h36;
	localparam logic [7:0] ADDR_RT_RES0_LOW    = 8'h37;
	localparam logic [7:0] ADDR_RT_RES0_HIGH   = 8'h38;
	localparam logic [7:0] ADDR_RT_RES1_LOW    = 8'h39;
	localparam logic [7:0] ADDR_RT_RES1_HIGH   = 8'h3a;
	localparam logic [7:0] ADDR_SW_RES_LOW     = 8'h3b;
	localparam logic [7:0] ADDR_SW_RES_HIGH    = 8'h3c;

	// Front-end control bit positions
	localparam int BIT_ISOURCE       = 7;
	localparam int BIT_THERMAL2_MON  = 6;
	localparam int BIT_THERMAL1_MON  = 5;
	localparam int BIT_CH11_DIV      = 4;
	localparam int BIT_SYS_QUARTER   = 3;
	localparam int BIT_CH2_DIV       = 2;
	localparam int BIT_TEMP1_EN      = 0;
	localparam logic [7:0] FRONTEND_WMASK = 8'hfd;

	// Scaler control bit positions
	localparam int BIT_BAT_QUARTER   = 3;
	localparam int BIT_CH18_SCALER   = 2;
	localparam logic [7:0] SCALER_WMASK = 8'h0f;

	// Start/status bit positions
	localparam int BIT_SW_START      = 3;
	localparam int BIT_RT_DONE       = 2;
	localparam int BIT_SW_DONE       = 1;
	localparam int BIT_BUSY          = 0;

	// Reset values
	localparam logic [7:0]  FRONTEND_RESET = 8'h00;
	localparam logic [3:0]  SCALER_RESET   = 4'h0;
	localparam logic [18:0] RT_MASK_RESET  = 19'h0_0000;
	localparam logic [4:0]  SW_CODE_RESET  = 5'h00;
	localparam logic        DONE_RESET     = 1'b1;

	// Channel numbering and read answers while a clash is flagged
	localparam int          NUM_CHANNELS   = 19;
	localparam logic [4:0]  LAST_CHANNEL   = 5'h12;
	localparam logic [7:0]  CLASH_LOW_READ = 8'h00;
	localparam logic [7:0]  CLASH_HIGH_READ = 8'h10;
	localparam logic [1:0]  SENSE_OFF      = 2'h0;

	// Front-end steering bundle
	typedef struct packed {
		logic       thermal2_monitor_enable;
		logic       thermal1_monitor_enable;
		logic       chan11_divider_enable;
		logic       system_supply_quarter_divider;
		logic       chan2_divider_enable;
		logic       input1_temperature_enable;
		logic       battery_quarter_scaler;
		logic       chan18_scaler_enable;
	} acs_frontend_t;

	// Conversion request to the analogue converter
	typedef struct packed {
		logic       start;
		logic [4:0] channel;
	} acs_conv_req_t;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_RT_FIRST,
		ST_RT_SECOND,
		ST_SW
	} acs_state_t;

endpackage

// ### acs_sequencer.sv
/*
 * Conversion sequencer and register file of the general converter.
 * Holds front-end controls, real-time channel mask, software channel code,
 * start/status, and the three result register pairs with read clash flags.
 * Assumes the register port and all pins are synchronous to clk_in, except
 * the real-time start pin, which is synchronised here. The converter answers
 * each start with one conv_done_in pulse carrying the 12-bit result.
 */

`timescale 1ns/1ps

module acs_sequencer (
	input  wire logic                   clk_in,            // 250 MHz device clock
	input  wire logic                   rst_n_in,          // Async reset, active low
	input  wire logic [7:0]             reg_addr_in,       // Register offset
	input  wire logic                   reg_wr_in,         // Write strobe, one cycle
	input  wire logic                   reg_rd_in,         // Read strobe, one cycle
	input  wire logic [7:0]             reg_wdata_in,      // Write data
	output logic      [7:0]             reg_rdata_out,     // Read data, one cycle later
	input  wire logic                   fuse_battery_detect_enable_in, // Fuse bit
	input  wire logic                   realtime_start_pin_in, // Real-time start pin
	input  wire logic                   conv_done_in,      // Converter result valid
	input  wire logic [11:0]            conv_result_in,    // Converter result
	output acs_pkg::acs_conv_req_t      conv_req_out,      // Start pulse and channel
	output acs_pkg::acs_frontend_t      frontend_out,      // Front-end steering
	output logic                        input0_current_source_out, // Input-0 source on
	output logic      [1:0]             input3_sense_current_out,  // Input-3 current code
	output logic                        rt_done_event_out, // Real-time end event pulse
	output logic                        sw_done_event_out  // Software end event pulse
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Lowest set channel of a mask: bit 5 is valid, bits 4:0 the index
	function automatic logic [5:0] lowest_channel(input logic [18:0] mask);
		logic [5:0] res;
		res = 6'h00;
		for (int i = acs_pkg::NUM_CHANNELS - 1; i >= 0; i--)
		begin
			if (mask[i])
			begin
				res = {1'b1, 5'(i)};
			end
		end
		return res;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [7:0]          frontend_q;
	logic [3:0]          scaler_q;
	logic [18:0]         rt_mask_q;
	logic [4:0]          sw_code_q;
	logic                rt_done_q;
	logic                sw_done_q;
	logic                rt_pend_q;
	logic                sw_pend_q;
	logic [4:0]          sw_chan_q;
	logic [4:0]          rt_second_q;
	logic                rt_has_second_q;
	logic [11:0]         rt_res0_q;
	logic [11:0]         rt_res1_q;
	logic [11:0]         sw_res_q;
	logic                rt_clash_q;
	logic                sw_clash_q;
	logic [2:0]          pin_sync_q;
	acs_pkg::acs_state_t state_q;
	acs_pkg::acs_state_t state_d;
	logic                conv_start_d;
	logic [4:0]          conv_chan_d;
	logic                rt_end;
	logic                sw_end;
	logic                rt_edge;
	logic                sw_start_wr;
	logic                rt_running;
	logic                sw_running;
	logic [5:0]          rt_first_sel;
	logic [5:0]          rt_second_sel;
	logic                rd_rt_res;
	logic                rd_sw_res;
	logic [7:0]          rdata_d;

	assign rt_running = (state_q == acs_pkg::ST_RT_FIRST) || (state_q == acs_pkg::ST_RT_SECOND);
	assign sw_running = (state_q == acs_pkg::ST_SW);
	assign rt_first_sel  = lowest_channel(rt_mask_q);
	assign rt_second_sel = lowest_channel(rt_mask_q & ~(19'h0_0001 << rt_first_sel[4:0]));

	////////////////////////////////////////////////////////////////////////////
	// Start pin synchroniser and request detection

	// Third stage only serves the edge detector, never the first stage
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			pin_sync_q <= 3'h0;
		else
			pin_sync_q <= {pin_sync_q[1:0], realtime_start_pin_in};
	end

	// Edges that land while a real-time request is queued or running are dropped
	assign rt_edge = pin_sync_q[1] && !pin_sync_q[2] && !rt_running && !rt_pend_q;

	// A written zero leaves everything alone; out-of-range codes start nothing
	assign sw_start_wr = reg_wr_in && (reg_addr_in == acs_pkg::ADDR_START_STATUS)
		&& reg_wdata_in[acs_pkg::BIT_SW_START] && (sw_code_q <= acs_pkg::LAST_CHANNEL)
		&& !sw_running && !sw_pend_q;

	////////////////////////////////////////////////////////////////////////////
	// Control registers

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			frontend_q <= acs_pkg::FRONTEND_RESET;
			scaler_q   <= acs_pkg::SCALER_RESET;
			sw_code_q  <= acs_pkg::SW_CODE_RESET;
		end
		else if (reg_wr_in)
		begin
			unique case (reg_addr_in)
				acs_pkg::ADDR_FRONTEND_CTRL:
					frontend_q <= reg_wdata_in & acs_pkg::FRONTEND_WMASK;
				acs_pkg::ADDR_SCALER_CTRL:
					scaler_q <= reg_wdata_in[3:0];
				acs_pkg::ADDR_SW_CHAN_SEL:
					sw_code_q <= reg_wdata_in[4:0];
				default:
					frontend_q <= frontend_q;
			endcase
		end
	end

	// Mask is frozen from request to end so the pair and the read-back stay coherent
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			rt_mask_q <= acs_pkg::RT_MASK_RESET;
		else if (reg_wr_in && !rt_running && !rt_pend_q)
		begin
			if (reg_addr_in == acs_pkg::ADDR_RT_SEL_LOW)
				rt_mask_q[7:0] <= reg_wdata_in;
			else if (reg_addr_in == acs_pkg::ADDR_RT_SEL_MID)
				rt_mask_q[15:8] <= reg_wdata_in;
			else if (reg_addr_in == acs_pkg::ADDR_RT_SEL_HIGH)
				rt_mask_q[18:16] <= reg_wdata_in[2:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Request queue and done flags

	// Done drops as soon as a request is taken, so a queued one also reads zero
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rt_pend_q <= 1'b0;
			sw_pend_q <= 1'b0;
			rt_done_q <= acs_pkg::DONE_RESET;
			sw_done_q <= acs_pkg::DONE_RESET;
			sw_chan_q <= 5'h00;
		end
		else
		begin
			if (rt_edge)
				rt_pend_q <= 1'b1;
			else if (state_q == acs_pkg::ST_IDLE)
				rt_pend_q <= 1'b0;
			if (sw_start_wr)
			begin
				sw_pend_q <= 1'b1;
				sw_chan_q <= sw_code_q;
			end
			else if (state_q == acs_pkg::ST_IDLE && !rt_pend_q)
				sw_pend_q <= 1'b0;
			if (rt_end)
				rt_done_q <= 1'b1;
			else if (rt_edge)
				rt_done_q <= 1'b0;
			if (sw_end)
				sw_done_q <= 1'b1;
			else if (sw_start_wr)
				sw_done_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sequencer

	// Real-time work wins when both wait; the software request stays queued
	always_comb
	begin
		state_d      = state_q;
		conv_start_d = 1'b0;
		conv_chan_d  = conv_req_out.channel;
		rt_end       = 1'b0;
		sw_end       = 1'b0;
		unique case (state_q)
			acs_pkg::ST_IDLE:
			begin
				if (rt_pend_q)
				begin
					if (rt_first_sel[5])
					begin
						state_d      = acs_pkg::ST_RT_FIRST;
						conv_start_d = 1'b1;
						conv_chan_d  = rt_first_sel[4:0];
					end
					else
						rt_end = 1'b1; // Empty mask ends at once
				end
				else if (sw_pend_q)
				begin
					state_d      = acs_pkg::ST_SW;
					conv_start_d = 1'b1;
					conv_chan_d  = sw_chan_q;
				end
			end
			acs_pkg::ST_RT_FIRST:
			begin
				if (conv_done_in)
				begin
					if (rt_has_second_q)
					begin
						state_d      = acs_pkg::ST_RT_SECOND;
						conv_start_d = 1'b1;
						conv_chan_d  = rt_second_q;
					end
					else
					begin
						state_d = acs_pkg::ST_IDLE;
						rt_end  = 1'b1;
					end
				end
			end
			acs_pkg::ST_RT_SECOND:
			begin
				if (conv_done_in)
				begin
					state_d = acs_pkg::ST_IDLE;
					rt_end  = 1'b1;
				end
			end
			acs_pkg::ST_SW:
			begin
				if (conv_done_in)
				begin
					state_d = acs_pkg::ST_IDLE;
					sw_end  = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_q         <= acs_pkg::ST_IDLE;
			conv_req_out    <= '0;
			rt_second_q     <= 5'h00;
			rt_has_second_q <= 1'b0;
		end
		else
		begin
			state_q              <= state_d;
			conv_req_out.start   <= conv_start_d;
			conv_req_out.channel <= conv_chan_d;
			if (state_q == acs_pkg::ST_IDLE && rt_pend_q)
			begin
				rt_second_q     <= rt_second_sel[4:0];
				rt_has_second_q <= rt_second_sel[5];
			end
		end
	end

	// Results land from the converter; the second pair waits for a second channel
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rt_res0_q <= 12'h000;
			rt_res1_q <= 12'h000;
			sw_res_q  <= 12'h000;
		end
		else if (conv_done_in)
		begin
			if (state_q == acs_pkg::ST_RT_FIRST)
				rt_res0_q <= conv_result_in;
			else if (state_q == acs_pkg::ST_RT_SECOND)
				rt_res1_q <= conv_result_in;
			else if (state_q == acs_pkg::ST_SW)
				sw_res_q <= conv_result_in;
		end
	end

	// End events go to the interrupt controller as one-cycle pulses
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rt_done_event_out <= 1'b0;
			sw_done_event_out <= 1'b0;
		end
		else
		begin
			rt_done_event_out <= rt_end;
			sw_done_event_out <= sw_end;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read clash flags and read data

	assign rd_rt_res = reg_rd_in && (reg_addr_in >= acs_pkg::ADDR_RT_RES0_LOW)
		&& (reg_addr_in <= acs_pkg::ADDR_RT_RES1_HIGH);
	assign rd_sw_res = reg_rd_in && ((reg_addr_in == acs_pkg::ADDR_SW_RES_LOW)
		|| (reg_addr_in == acs_pkg::ADDR_SW_RES_HIGH));

	// A clashing read in the last cycle of a sequence keeps the flag: set wins
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rt_clash_q <= 1'b0;
			sw_clash_q <= 1'b0;
		end
		else
		begin
			if (rd_rt_res && rt_running)
				rt_clash_q <= 1'b1;
			else if (!rt_running)
				rt_clash_q <= 1'b0;
			if (rd_sw_res && sw_running)
				sw_clash_q <= 1'b1;
			else if (!sw_running)
				sw_clash_q <= 1'b0;
		end
	end

	// Clash answer applies to the very read that raises the flag
	always_comb
	begin
		rdata_d = 8'h00;
		unique case (reg_addr_in)
			acs_pkg::ADDR_FRONTEND_CTRL: rdata_d = frontend_q;
			acs_pkg::ADDR_SCALER_CTRL:   rdata_d = {4'h0, scaler_q};
			acs_pkg::ADDR_RT_SEL_LOW:    rdata_d = rt_mask_q[7:0];
			acs_pkg::ADDR_RT_SEL_MID:    rdata_d = rt_mask_q[15:8];
			acs_pkg::ADDR_RT_SEL_HIGH:   rdata_d = {5'h00, rt_mask_q[18:16]};
			acs_pkg::ADDR_SW_CHAN_SEL:   rdata_d = {3'h0, sw_code_q};
			acs_pkg::ADDR_START_STATUS:
				rdata_d = {5'h00, rt_done_q, sw_done_q, (state_q != acs_pkg::ST_IDLE)};
			acs_pkg::ADDR_RT_RES0_LOW:
				rdata_d = (rt_clash_q || rt_running) ? acs_pkg::CLASH_LOW_READ
					: rt_res0_q[7:0];
			acs_pkg::ADDR_RT_RES0_HIGH:
				rdata_d = (rt_clash_q || rt_running) ? acs_pkg::CLASH_HIGH_READ
					: {4'h0, rt_res0_q[11:8]};
			acs_pkg::ADDR_RT_RES1_LOW:
				rdata_d = (rt_clash_q || rt_running) ? acs_pkg::CLASH_LOW_READ
					: rt_res1_q[7:0];
			acs_pkg::ADDR_RT_RES1_HIGH:
				rdata_d = (rt_clash_q || rt_running) ? acs_pkg::CLASH_HIGH_READ
					: {4'h0, rt_res1_q[11:8]};
			acs_pkg::ADDR_SW_RES_LOW:
				rdata_d = (sw_clash_q || sw_running) ? acs_pkg::CLASH_LOW_READ
					: sw_res_q[7:0];
			acs_pkg::ADDR_SW_RES_HIGH:
				rdata_d = (sw_clash_q || sw_running) ? acs_pkg::CLASH_HIGH_READ
					: {4'h0, sw_res_q[11:8]};
			default:                     rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			reg_rdata_out <= 8'h00;
		else if (reg_rd_in)
			reg_rdata_out <= rdata_d;
	end

	////////////////////////////////////////////////////////////////////////////
	// Front-end steering outputs

	// Registered again so every output leaves straight from a flop
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			frontend_out              <= '0;
			input0_current_source_out <= 1'b0;
			input3_sense_current_out  <= acs_pkg::SENSE_OFF;
		end
		else
		begin
			input0_current_source_out <= frontend_q[acs_pkg::BIT_ISOURCE]
				&& fuse_battery_detect_enable_in;
			frontend_out.thermal2_monitor_enable <= frontend_q[acs_pkg::BIT_THERMAL2_MON];
			frontend_out.thermal1_monitor_enable <= frontend_q[acs_pkg::BIT_THERMAL1_MON];
			frontend_out.chan11_divider_enable   <= frontend_q[acs_pkg::BIT_CH11_DIV];
			frontend_out.chan2_divider_enable    <= frontend_q[acs_pkg::BIT_CH2_DIV];
			frontend_out.system_supply_quarter_divider <= frontend_q[acs_pkg::BIT_SYS_QUARTER];
			frontend_out.input1_temperature_enable <= frontend_q[acs_pkg::BIT_TEMP1_EN];
			frontend_out.battery_quarter_scaler  <= scaler_q[acs_pkg::BIT_BAT_QUARTER];
			frontend_out.chan18_scaler_enable    <= scaler_q[acs_pkg::BIT_CH18_SCALER];
			// Current source only burns power while a conversion is under way
			input3_sense_current_out <= (state_d != acs_pkg::ST_IDLE) ? scaler_q[1:0]
				: acs_pkg::SENSE_OFF;
		end
	end

endmodule

// ### acs_sequencer_properties.sv
/*
 * Port checks for the converter sequencer.
 * Assumes one clock and the asynchronous active-low reset of the block.
 */
`timescale 1ns/1ps

module acs_sequencer_properties (
	input wire logic              clk_in,                        // Device clock
	input wire logic              rst_n_in,                      // Reset, active low
	input wire logic [7:0]        reg_addr_in,                   // Register offset
	input wire logic              reg_wr_in,                     // Write strobe
	input wire logic              reg_rd_in,                     // Read strobe
	input wire logic [7:0]        reg_wdata_in,                  // Write data
	input wire logic [7:0]        reg_rdata_out,                 // Read data
	input wire logic              fuse_battery_detect_enable_in, // Fuse bit
	input wire logic              conv_done_in,                  // Result valid
	input acs_pkg::acs_conv_req_t conv_req_out,                  // Start and channel
	input acs_pkg::acs_frontend_t frontend_out,                  // Front-end steering
	input wire logic              input0_current_source_out,     // Input-0 source
	input wire logic              rt_done_event_out,             // Real-time end pulse
	input wire logic              sw_done_event_out              // Software end pulse
);
	default clocking dcb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	////////////////////////////////////////
	// Reserved bits must read zero one cycle after the read strobe
	rsv_status_a: assert property (
		reg_rd_in && reg_addr_in == acs_pkg::ADDR_START_STATUS |=> reg_rdata_out[7:3] == 5'h00)
		else $error("status reserved bits set");
	rsv_front_a: assert property (
		reg_rd_in && reg_addr_in == acs_pkg::ADDR_FRONTEND_CTRL |=> !reg_rdata_out[1])
		else $error("front-end reserved bit set");
	rsv_scaler_a: assert property (
		reg_rd_in && reg_addr_in == acs_pkg::ADDR_SCALER_CTRL |=> reg_rdata_out[7:4] == 4'h0)
		else $error("scaler reserved bits set");
	rsv_code_a: assert property (
		reg_rd_in && reg_addr_in == acs_pkg::ADDR_SW_CHAN_SEL |=> reg_rdata_out[7:5] == 3'h0)
		else $error("channel code reserved bits set");
	// Steering shows a control write two edges later: register, then output flop
	front_write_a: assert property (
		reg_wr_in && reg_addr_in == acs_pkg::ADDR_FRONTEND_CTRL |=> ##1
		frontend_out[7:2] == {$past(reg_wdata_in[6:2], 2), $past(reg_wdata_in[0], 2)})
		else $error("front-end steering wrong after write");
	scaler_write_a: assert property (
		reg_wr_in && reg_addr_in == acs_pkg::ADDR_SCALER_CTRL |=> ##1
		frontend_out[1:0] == $past(reg_wdata_in[3:2], 2))
		else $error("scaler steering wrong after write");
	// The fuse gates the source, so a source without fuse is a leak
	source_fuse_a: assert property (
		input0_current_source_out |-> $past(fuse_battery_detect_enable_in))
		else $error("input-0 source on without fuse");
	chan_range_a: assert property (
		conv_req_out.start |-> conv_req_out.channel <= acs_pkg::LAST_CHANNEL)
		else $error("start on a channel beyond the last");
	start_pulse_a: assert property (
		conv_req_out.start |=> !conv_req_out.start)
		else $error("start pulse longer than one cycle");
	sw_event_a: assert property (
		sw_done_event_out |-> $past(conv_done_in))
		else $error("software end event without a result");

	cov_sw: cover property (sw_done_event_out);
	cov_rt: cover property (rt_done_event_out);
	cov_last: cover property (conv_req_out.start && conv_req_out.channel == acs_pkg::LAST_CHANNEL);
endmodule

// ### acs_conv_model.sv
/*
 * Behavioural model of the analogue converter.
 * Assumes one start at a time; the result comes lat_in plus two cycles later.
 */
`timescale 1ns/1ps

module acs_conv_model (
	input  wire logic              clk_in,     // Device clock
	input  wire logic              rst_n_in,   // Reset, active low
	input  wire logic [3:0]        lat_in,     // Extra cycles per conversion
	input  acs_pkg::acs_conv_req_t req_in,     // Start pulse and channel
	output logic                   done_out,   // Result valid pulse
	output logic      [11:0]       result_out  // Result, scrambled when not valid
);
	logic       run_q;
	logic [3:0] cnt_q;
	logic [4:0] ch_q;

	// Result carries the channel so a swapped slot shows; it toggles when stale
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			run_q <= 1'b0;
			cnt_q <= 4'h0;
			ch_q <= 5'h00;
			done_out <= 1'b0;
			result_out <= 12'h000;
		end
		else
		begin
			done_out <= run_q && cnt_q == 4'h0;
			result_out <= (run_q && cnt_q == 4'h0) ? {ch_q, 7'h35} : ~result_out;
			if (req_in.start)
			begin
				run_q <= 1'b1;
				cnt_q <= lat_in;
				ch_q <= req_in.channel;
			end
			else if (run_q && cnt_q == 4'h0)
				run_q <= 1'b0;
			else if (run_q)
				cnt_q <= cnt_q - 4'h1;
		end
	end
endmodule

// ### acs_sequencer_tb.sv
/*
 * Self-checking bench for the converter sequencer and its converter model.
 * Assumes the strobe timing and latencies of the register port contract.
 */
`timescale 1ns/1ps

module acs_sequencer_tb;
	logic                   clk_in;
	logic                   rst_n_in;
	logic [7:0]             reg_addr_in;
	logic                   reg_wr_in;
	logic                   reg_rd_in;
	logic [7:0]             reg_wdata_in;
	logic [7:0]             reg_rdata_out;
	logic                   fuse_battery_detect_enable_in;
	logic                   realtime_start_pin_in;
	logic                   conv_done_in;
	logic [11:0]            conv_result_in;
	acs_pkg::acs_conv_req_t conv_req_out;
	acs_pkg::acs_frontend_t frontend_out;
	logic                   input0_current_source_out;
	logic [1:0]             input3_sense_current_out;
	logic                   rt_done_event_out;
	logic                   sw_done_event_out;
	logic [3:0]             lat;
	logic [2:0]             ev;
	int                     num_errors = 0;
	int                     checks_done = 0;
	int                     cycles = 0;
	int                     starts = 0;

	acs_sequencer i_acs_sequencer (.clk_in, .rst_n_in, .reg_addr_in, .reg_wr_in, .reg_rd_in,
		.reg_wdata_in, .reg_rdata_out, .fuse_battery_detect_enable_in, .realtime_start_pin_in,
		.conv_done_in, .conv_result_in, .conv_req_out, .frontend_out, .input0_current_source_out,
		.input3_sense_current_out, .rt_done_event_out, .sw_done_event_out);
	acs_conv_model i_acs_conv_model (.clk_in, .rst_n_in, .lat_in(lat), .req_in(conv_req_out),
		.done_out(conv_done_in), .result_out(conv_result_in));
	assign ev = {rt_done_event_out, sw_done_event_out, conv_req_out.start};

	initial
	begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end

	// Stray starts are counted; the cycle ceiling cuts a hang short
	always @(posedge clk_in)
	begin
		cycles++;
		if (conv_req_out.start === 1'b1)
			starts++;
		if (cycles == 5000)
		begin
			num_errors++;
			summarize();
		end
	end

	////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge clk_in);
			#1;
		end
	endtask

	task automatic chk(input string what, input logic [11:0] seen, input logic [11:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Strobe is dropped a cycle before the next access may raise it
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		reg_addr_in = a;
		reg_wdata_in = v;
		reg_wr_in = 1'b1;
		tick(1);
		reg_wr_in = 1'b0;
		tick(1);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		tick(1);
		reg_rd_in = 1'b0;
		chk($sformatf("reg %h", a), {4'h0, reg_rdata_out}, {4'h0, exp});
		tick(1);
	endtask

	// Wait for start (0), software end (1) or real-time end (2)
	task automatic await(input int sel);
		int n;
		n = 0;
		while (ev[sel] !== 1'b1 && n < 60)
		begin
			tick(1);
			n++;
		end
		chk("event", {11'h000, ev[sel]}, 12'h001);
	endtask

	task automatic pulse;
		realtime_start_pin_in = 1'b1;
		tick(4);
		realtime_start_pin_in = 1'b0;
	endtask

	////////////////////////////////////////
	task automatic t_reset;
		logic [7:0] regs [10] = '{8'h2e, 8'h2f, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37,
			8'h38, 8'h40};
		foreach (regs[i])
			rdc(regs[i], regs[i] == 8'h36 ? 8'h06 : 8'h00);
	endtask

	task automatic t_ctrl;
		wr(8'h2e, 8'hff);
		rdc(8'h2e, 8'hfd);
		chk("front", 12'(frontend_out[7:2]), 12'h03f);
		chk("source", 12'(input0_current_source_out), 12'h000);
		fuse_battery_detect_enable_in = 1'b1;
		tick(2);
		chk("source", 12'(input0_current_source_out), 12'h001);
		wr(8'h2e, 8'h08);
		chk("front", 12'(frontend_out[7:2]), 12'h004);
		chk("source", 12'(input0_current_source_out), 12'h000);
		wr(8'h2f, 8'hff);
		rdc(8'h2f, 8'h0f);
		chk("scaler", 12'(frontend_out[1:0]), 12'h003);
	endtask

	// Every channel code, each with one of the four sense currents
	task automatic t_sw;
		int s;
		lat = 4'd8;
		// Channels 2 and 11 may only be converted with their dividers on
		wr(8'h2e, 8'h14);
		chk("front", 12'(frontend_out[7:2]), 12'h00a);
		wr(8'h36, 8'hf7);
		tick(4);
		chk("starts", 12'(starts), 12'h000);
		for (int c = 0; c < 32; c++)
		begin
			s = starts;
			wr(8'h2f, {6'h00, 2'(c)});
			wr(8'h35, 8'(c));
			wr(8'h36, 8'h08);
			if (c < 19)
			begin
				await(0);
				chk("channel", 12'(conv_req_out.channel), 12'(c));
				chk("sense", 12'(input3_sense_current_out), 12'(c % 4));
				rdc(8'h36, 8'h05);
				await(1);
				chk("sense", 12'(input3_sense_current_out), 12'h000);
			end
			else
			begin
				tick(6);
				chk("starts", 12'(starts - s), 12'h000);
			end
			rdc(8'h36, 8'h06);
		end
	endtask

	task automatic t_rt;
		int s;
		lat = 4'd12;
		wr(8'h33, 8'h28);
		wr(8'h34, 8'h04);
		s = starts;
		pulse();
		await(0);
		chk("channel", 12'(conv_req_out.channel), 12'h00b);
		rdc(8'h36, 8'h03);
		rdc(8'h37, 8'h00);
		rdc(8'h38, 8'h10);
		wr(8'h33, 8'h00);
		pulse();
		await(0);
		chk("channel", 12'(conv_req_out.channel), 12'h00d);
		await(2);
		tick(20);
		chk("starts", 12'(starts - s), 12'h002);
		rdc(8'h33, 8'h28);
		rdc(8'h37, 8'hb5);
		rdc(8'h38, 8'h05);
		rdc(8'h3a, 8'h06);
	endtask

	// Software start queued behind a running real-time sequence
	task automatic t_both;
		int s;
		wr(8'h33, 8'h00);
		wr(8'h34, 8'h00);
		wr(8'h32, 8'h04);
		wr(8'h35, 8'h05);
		pulse();
		wr(8'h36, 8'h08);
		rdc(8'h36, 8'h01);
		await(2);
		// The queued conversion leaves idle one cycle after the real-time end
		tick(1);
		rdc(8'h36, 8'h05);
		await(1);
		rdc(8'h36, 8'h06);
		wr(8'h32, 8'h00);
		s = starts;
		realtime_start_pin_in = 1'b1;
		await(2);
		realtime_start_pin_in = 1'b0;
		tick(4);
		chk("starts", 12'(starts - s), 12'h000);
		rdc(8'h36, 8'h06);
	endtask

	task automatic summarize;
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	initial
	begin
		rst_n_in = 1'b0;
		reg_addr_in = 8'h00;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		reg_wdata_in = 8'h00;
		fuse_battery_detect_enable_in = 1'b0;
		realtime_start_pin_in = 1'b0;
		lat = 4'd8;
		tick(6);
		rst_n_in = 1'b1;
		tick(1);
		t_reset();
		t_ctrl();
		t_sw();
		t_rt();
		t_both();
		summarize();
	end
endmodule

bind acs_sequencer acs_sequencer_properties i_acs_sequencer_properties (.clk_in, .rst_n_in,
	.reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
	.fuse_battery_detect_enable_in, .conv_done_in, .conv_req_out, .frontend_out,
	.input0_current_source_out, .rt_done_event_out, .sw_done_event_out);
